// file: boot_seq_pkg.sv
/*
  boot_seq_pkg: shared constants and types for the sensor boot / standby
  sequencer and its host-side controller.
  assumes a single 20 MHz clock shared by both ends.
*/
`default_nettype none
package boot_seq_pkg;
  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 20000000;
  localparam int OTP_LOAD_CYCLES = 160000;
  localparam int PLL_LOCK_US = 1000;
  localparam int SUPPLY_SETTLE_US = 1000;
  localparam int PLL_LOCK_CYCLES = PLL_LOCK_US * (CLK_HZ / 1000000);
  localparam int SUPPLY_SETTLE_CYCLES =
    SUPPLY_SETTLE_US * (CLK_HZ / 1000000);
  localparam int CNT_W = 18;
  localparam logic [CNT_W-1:0] CNT_ZERO = 18'h00000;
  localparam logic [CNT_W-1:0] CNT_ONE = 18'h00001;

  // ----------------------------------------------------------------
  // device states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    DEV_HARD_STBY = 3'b000,
    DEV_OTP_LOAD = 3'b001,
    DEV_SOFT_STBY = 3'b011,
    DEV_PLL_LOCK = 3'b010,
    DEV_STREAM = 3'b110,
    DEV_DRAIN = 3'b111
  } dev_state_t;

  // ----------------------------------------------------------------
  // host states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    HOST_OFF = 3'b000,
    HOST_SETTLE = 3'b001,
    HOST_BOOT_WAIT = 3'b011,
    HOST_IDLE = 3'b111,
    HOST_STARTING = 3'b110,
    HOST_RUN = 3'b100,
    HOST_STOPPING = 3'b101
  } host_state_t;
endpackage : boot_seq_pkg
`default_nettype wire

// file: boot_seq_if.sv
/*
  boot_seq_if: the pins between the host controller and the sensor
  sequencer: active-low chip reset, the stream-run select write strobe,
  and the device's status lines back to the host.
  assumes both ends sit on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
interface boot_seq_if;
  logic chip_reset_n;
  logic mode_wr;
  logic mode_wdata;
  logic line_stop;
  logic boot_done;
  logic pll_locked;
  logic streaming;
  logic frame_end;
  logic line_end;

  modport device (
    input chip_reset_n, mode_wr, mode_wdata, line_stop,
    output boot_done, pll_locked, streaming, frame_end, line_end
  );
  modport host (
    output chip_reset_n, mode_wr, mode_wdata, line_stop,
    input boot_done, pll_locked, streaming, frame_end, line_end
  );
endinterface : boot_seq_if
`default_nettype wire

// file: sensor_boot_standby_sequencer.sv
/*
  sensor_boot_standby_sequencer: device end. walks hard standby, one-time
  programmable memory load, software standby, pll lock and streaming, and
  leaves streaming on a standby write only at a frame or line boundary; reset low ends it at once.
  assumes chip reset and writes come from logic on the same clock; the
  reset pin is still treated as asynchronous to be safe.
*/
// Notes on behaviour
// RULE1: host holds reset low during supply ramp
// RULE2: clock may start anytime during power-up
// RULE3: reset released at least 1.0 ms later
// RULE4: boot starts on reset release
// RULE5: memory load done within 160000 cycles
// RULE6: host waits 160000 cycles before transactions
// RULE7: pll locks within 1.0 ms, then stream
// RULE8: host stops streaming before asserting reset; the host controller asserts it at once on a supply drop, even while streaming
// RULE9: writing 0 to mode select enters standby
// RULE10: stop only at frame or line end
// RULE11: reset low holds hard standby
// RULE12: reset asserted before supplies removed
// RULE13: boot-done flag readable by host
`timescale 1ns/1ns
`default_nettype none
module sensor_boot_standby_sequencer #(
  parameter int OTP_CYCLES = boot_seq_pkg::OTP_LOAD_CYCLES,
  parameter int LOCK_CYCLES = boot_seq_pkg::PLL_LOCK_CYCLES,
  parameter int LINE_CYCLES = 64,
  parameter int FRAME_LINES = 16
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic srst_i,
  // link to host
  boot_seq_if.device link,
  // user side
  output logic one_time_prog_memory_load_o,
  output logic pll_enable_o,
  output logic hard_standby_o
);
  // ----------------------------------------------------------------
  // reset pin synchroniser
  // ----------------------------------------------------------------
  // the pin may come from another domain, so it is never used raw
  logic [2:0] rst_sync;
  logic rst_low;
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      rst_sync <= 3'h0;
      rst_low <= 1'b1;
    end else begin
      rst_sync <= {rst_sync[1:0], link.chip_reset_n};
      // a change counts once the last two stages agree
      if (rst_sync[2] == rst_sync[1]) begin
        rst_low <= ~rst_sync[2];
      end
    end
  end

  // ----------------------------------------------------------------
  // state machine
  // ----------------------------------------------------------------
  boot_seq_pkg::dev_state_t state, next_state;
  logic [boot_seq_pkg::CNT_W-1:0] cnt, next_cnt;
  logic [7:0] line_cnt;
  logic [7:0] line_idx;
  logic line_stop_cfg;

  wire run_wr = link.mode_wr & link.mode_wdata;
  wire stop_wr = link.mode_wr & ~link.mode_wdata;
  wire at_line_end = (line_cnt == 8'(LINE_CYCLES - 1));
  wire at_frame_end = at_line_end & (line_idx == 8'(FRAME_LINES - 1));
  wire at_boundary = line_stop_cfg ? at_line_end : at_frame_end; // [RULE10]
  wire cnt_done = (cnt == boot_seq_pkg::CNT_ZERO);

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    if (cnt != boot_seq_pkg::CNT_ZERO) begin
      next_cnt = cnt - boot_seq_pkg::CNT_ONE;
    end
    unique case (state)
      boot_seq_pkg::DEV_HARD_STBY: begin
        next_state = boot_seq_pkg::DEV_OTP_LOAD; // [RULE4]
        next_cnt = boot_seq_pkg::CNT_W'(OTP_CYCLES - 1); // [RULE5]
      end
      boot_seq_pkg::DEV_OTP_LOAD: begin
        if (cnt_done) begin
          next_state = boot_seq_pkg::DEV_SOFT_STBY;
        end
      end
      boot_seq_pkg::DEV_SOFT_STBY: begin
        if (run_wr) begin
          next_state = boot_seq_pkg::DEV_PLL_LOCK;
          next_cnt = boot_seq_pkg::CNT_W'(LOCK_CYCLES - 1); // [RULE7]
        end
      end
      // a stop in the lock wait needs no drain: no frame has begun
      boot_seq_pkg::DEV_PLL_LOCK: begin
        if (stop_wr) begin
          next_state = boot_seq_pkg::DEV_SOFT_STBY;
        end else if (cnt_done) begin
          next_state = boot_seq_pkg::DEV_STREAM; // [RULE7]
        end
      end
      boot_seq_pkg::DEV_STREAM: begin
        if (stop_wr) begin
          next_state = boot_seq_pkg::DEV_DRAIN; // [RULE9]
        end
      end
      // a run write in the drain resumes with no new lock wait
      boot_seq_pkg::DEV_DRAIN: begin
        if (run_wr) begin
          next_state = boot_seq_pkg::DEV_STREAM;
        end else if (at_boundary) begin
          next_state = boot_seq_pkg::DEV_SOFT_STBY; // [RULE10]
        end
      end
      default: begin
        next_state = boot_seq_pkg::DEV_HARD_STBY;
      end
    endcase
    // reset low beats any write, so nothing can leave hard standby
    if (rst_low) begin
      next_state = boot_seq_pkg::DEV_HARD_STBY; // [RULE11]
      next_cnt = boot_seq_pkg::CNT_ZERO;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      state <= boot_seq_pkg::DEV_HARD_STBY;
      cnt <= boot_seq_pkg::CNT_ZERO;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
    end
  end

  // ----------------------------------------------------------------
  // frame timing and configuration
  // ----------------------------------------------------------------
  // counters run only while pixels flow, so each start opens on
  // the first line of a fresh frame
  // limitation: line and frame sizes above 256 overflow the counters
  wire timing_run = (state == boot_seq_pkg::DEV_STREAM) ||
    (state == boot_seq_pkg::DEV_DRAIN);
  wire [7:0] next_line_cnt = at_line_end ? 8'h00 : line_cnt + 8'h01;
  wire [7:0] next_line_idx = at_frame_end ? 8'h00 :
    (at_line_end ? line_idx + 8'h01 : line_idx);

  always_ff @(posedge clock_i) begin
    if (srst_i || !timing_run) begin
      line_cnt <= 8'h00;
      line_idx <= 8'h00;
    end else begin
      line_cnt <= next_line_cnt;
      line_idx <= next_line_idx;
    end
  end

  // the stop mode is held during the drain so a change there cannot move the stop boundary
  always_ff @(posedge clock_i) begin
    if (srst_i || rst_low) begin
      line_stop_cfg <= 1'b0;
    end else begin
      if (state != boot_seq_pkg::DEV_DRAIN) begin
        line_stop_cfg <= link.line_stop;
      end
    end
  end

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  // outputs except frame_end and line_end follow the next state so they change with the state flops
  wire next_booted = (next_state != boot_seq_pkg::DEV_HARD_STBY) &&
    (next_state != boot_seq_pkg::DEV_OTP_LOAD);
  wire next_live = (next_state == boot_seq_pkg::DEV_STREAM) ||
    (next_state == boot_seq_pkg::DEV_DRAIN);
  wire next_pll_on = next_live ||
    (next_state == boot_seq_pkg::DEV_PLL_LOCK);
  wire next_loading = (next_state == boot_seq_pkg::DEV_OTP_LOAD);
  wire next_hard = (next_state == boot_seq_pkg::DEV_HARD_STBY);

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      link.boot_done <= 1'b0;
      link.pll_locked <= 1'b0;
      link.streaming <= 1'b0;
      link.frame_end <= 1'b0;
      link.line_end <= 1'b0;
      one_time_prog_memory_load_o <= 1'b0;
      pll_enable_o <= 1'b0;
      hard_standby_o <= 1'b1;
    end else begin
      link.boot_done <= next_booted; // [RULE13]
      link.pll_locked <= next_live; // [RULE7]
      link.streaming <= next_live;
      link.frame_end <= timing_run & at_frame_end;
      link.line_end <= timing_run & at_line_end;
      one_time_prog_memory_load_o <= next_loading; // [RULE5]
      pll_enable_o <= next_pll_on; // [RULE7]
      hard_standby_o <= next_hard; // [RULE11]
    end
  end
endmodule : sensor_boot_standby_sequencer
`default_nettype wire

// file: sensor_host_controller.sv
/*
  sensor_host_controller: host end. holds chip reset through supply
  ramp, waits the settle and boot times, starts and stops streaming, and
  powers down at once when supplies drop, even while still streaming.
  assumes the device end shares its clock.
*/
`timescale 1ns/1ns
`default_nettype none
module sensor_host_controller #(
  parameter int SETTLE_CYCLES = boot_seq_pkg::SUPPLY_SETTLE_CYCLES,
  parameter int BOOT_CYCLES = boot_seq_pkg::OTP_LOAD_CYCLES,
  parameter int LOCK_CYCLES = boot_seq_pkg::PLL_LOCK_CYCLES
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic srst_i,
  // link to device
  boot_seq_if.host link,
  // user side
  input wire logic supplies_ok_i,
  input wire logic stream_req_i,
  input wire logic line_stop_i,
  output logic ready_o,
  output logic running_o,
  output logic safe_off_o
);
  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  boot_seq_pkg::host_state_t state, next_state;
  logic [boot_seq_pkg::CNT_W-1:0] cnt, next_cnt;
  wire cnt_done = (cnt == boot_seq_pkg::CNT_ZERO);
  logic next_wr, next_wdata;

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_wr = 1'b0;
    next_wdata = 1'b0;
    if (!cnt_done) begin
      next_cnt = cnt - boot_seq_pkg::CNT_ONE;
    end
    unique case (state)
      boot_seq_pkg::HOST_OFF: begin
        if (supplies_ok_i) begin
          next_state = boot_seq_pkg::HOST_SETTLE;
          next_cnt = boot_seq_pkg::CNT_W'(SETTLE_CYCLES - 1); // [RULE3]
        end
      end
      boot_seq_pkg::HOST_SETTLE: begin
        if (cnt_done) begin
          next_state = boot_seq_pkg::HOST_BOOT_WAIT;
          next_cnt = boot_seq_pkg::CNT_W'(BOOT_CYCLES - 1); // [RULE6]
        end
      end
      boot_seq_pkg::HOST_BOOT_WAIT: begin
        if (cnt_done && link.boot_done) begin
          next_state = boot_seq_pkg::HOST_IDLE; // [RULE13]
        end
      end
      boot_seq_pkg::HOST_IDLE: begin
        if (stream_req_i) begin
          next_state = boot_seq_pkg::HOST_STARTING;
          next_cnt = boot_seq_pkg::CNT_W'(LOCK_CYCLES); // [RULE7]
          next_wr = 1'b1;
          next_wdata = 1'b1;
        end
      end
      boot_seq_pkg::HOST_STARTING: begin
        if (cnt_done && link.streaming) begin
          next_state = boot_seq_pkg::HOST_RUN; // [RULE7]
        end
      end
      boot_seq_pkg::HOST_RUN: begin
        if (!stream_req_i) begin
          next_state = boot_seq_pkg::HOST_STOPPING; // [RULE8]
          next_wr = 1'b1;
        end
      end
      boot_seq_pkg::HOST_STOPPING: begin
        if (!link.streaming) begin
          next_state = boot_seq_pkg::HOST_IDLE; // [RULE10]
        end
      end
      default: begin
        next_state = boot_seq_pkg::HOST_OFF;
      end
    endcase
    // supplies dropping forces reset; normal shutdown stops stream first
    if (!supplies_ok_i) begin
      next_state = boot_seq_pkg::HOST_OFF; // [RULE12]
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      state <= boot_seq_pkg::HOST_OFF;
      cnt <= boot_seq_pkg::CNT_ZERO;
      link.chip_reset_n <= 1'b0;
      link.mode_wr <= 1'b0;
      link.mode_wdata <= 1'b0;
      link.line_stop <= 1'b0;
      ready_o <= 1'b0;
      running_o <= 1'b0;
      safe_off_o <= 1'b1;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      // reset held low until the settle time is over
      link.chip_reset_n <= (next_state != boot_seq_pkg::HOST_OFF) &&
        (next_state != boot_seq_pkg::HOST_SETTLE); // [RULE1]
      link.mode_wr <= next_wr;
      link.mode_wdata <= next_wdata;
      link.line_stop <= line_stop_i;
      ready_o <= (next_state == boot_seq_pkg::HOST_IDLE);
      running_o <= (next_state == boot_seq_pkg::HOST_RUN);
      safe_off_o <= (next_state == boot_seq_pkg::HOST_OFF);
    end
  end
endmodule : sensor_host_controller
`default_nettype wire

// file: boot_seq_assertions.sv
/*
  boot_seq_assertions: timing checks on the host-device link.
  assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ns
`default_nettype none
module boot_seq_assertions #(
  parameter int OTP_CYCLES = 20,
  parameter int LOCK_CYCLES = 10,
  parameter int BOOT_CYCLES = 20,
  parameter int LINE_CYCLES = 8,
  parameter int FRAME_LINES = 4
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic srst_i,
  // link signals
  input wire logic chip_reset_n,
  input wire logic mode_wr,
  input wire logic mode_wdata,
  input wire logic line_stop,
  input wire logic boot_done,
  input wire logic pll_locked,
  input wire logic streaming,
  input wire logic frame_end,
  input wire logic line_end
);
  localparam int BOOT_MAX = OTP_CYCLES + 8;
  localparam int STOP_MAX = LINE_CYCLES * FRAME_LINES + 4;
  logic [17:0] since_rel;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);
  // ----------------------------------------------------------------
  // helper
  // ----------------------------------------------------------------
  // saturates so a long run never wraps back under the boot count
  always_ff @(posedge clock_i) begin
    if (srst_i || !chip_reset_n) since_rel <= 18'h00000;
    else if (since_rel != 18'h3FFFF) since_rel <= since_rel + 18'h00001;
  end
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  hold_stby_a:
    assert property (!chip_reset_n [*6] |-> !boot_done && !streaming)
    else $error("link active while chip reset held");
  boot_early_a:
    assert property ($rose(chip_reset_n) |-> ##OTP_CYCLES !boot_done)
    else $error("boot flag before load could finish");
  boot_late_a:
    assert property ($rose(chip_reset_n) |-> ##[1:BOOT_MAX] boot_done)
    else $error("boot load too slow");
  lock_time_a:
    assert property (mode_wr && mode_wdata && boot_done && !pll_locked
      |-> ##LOCK_CYCLES !streaming ##1 streaming)
    else $error("streaming not after pll lock time");
  pll_held_a:
    assert property ($rose(pll_locked)
      |-> $past(mode_wr && mode_wdata, LOCK_CYCLES + 1))
    else $error("pll lock reported before lock wait");
  stop_edge_a:
    assert property ($fell(streaming)
      |-> frame_end || (line_end && line_stop))
    else $error("stream stopped off a boundary");
  stop_time_a:
    assert property (mode_wr && !mode_wdata && streaming
      |-> ##[1:STOP_MAX] !streaming)
    else $error("standby write did not stop stream");
  wait_boot_a:
    assert property (mode_wr |-> boot_done && since_rel >= BOOT_CYCLES)
    else $error("write before boot wait");
  off_order_a:
    assert property ($fell(chip_reset_n) |-> !$past(streaming))
    else $error("chip reset while streaming");
  cover property ($rose(boot_done));
  cover property ($rose(streaming));
  cover property ($fell(streaming) && line_stop);
  cover property ($fell(streaming) && !line_stop);
endmodule : boot_seq_assertions
`default_nettype wire

// file: tb_top.sv
/*
  tb_top: joins host and sensor ends, drives the host user side.
  assumes the short test counts below in place of real ones.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  localparam int OTP_C = 20;
  localparam int LOCK_C = 10;
  localparam int SET_C = 10;
  localparam int LINE_C = 8;
  localparam int LINES_C = 4;
  logic clock_i = 1'b0;
  logic srst_i = 1'b1;
  logic sup_ok = 1'b0;
  logic req = 1'b0;
  logic lstop = 1'b0;
  logic load_o, pll_en, stby, ready, running, safe_off, seen;
  int n_mismatch = 0;
  int cmp_count = 0;
  int n;
  boot_seq_if i_boot_seq_if ();
  sensor_boot_standby_sequencer #(.OTP_CYCLES(OTP_C),
    .LOCK_CYCLES(LOCK_C), .LINE_CYCLES(LINE_C), .FRAME_LINES(LINES_C))
    i_sensor_boot_standby_sequencer (.clock_i(clock_i), .srst_i(srst_i),
    .link(i_boot_seq_if), .one_time_prog_memory_load_o(load_o),
    .pll_enable_o(pll_en), .hard_standby_o(stby));
  sensor_host_controller #(.SETTLE_CYCLES(SET_C), .BOOT_CYCLES(OTP_C),
    .LOCK_CYCLES(LOCK_C)) i_sensor_host_controller (.clock_i(clock_i),
    .srst_i(srst_i), .link(i_boot_seq_if), .supplies_ok_i(sup_ok),
    .stream_req_i(req), .line_stop_i(lstop), .ready_o(ready),
    .running_o(running), .safe_off_o(safe_off));
  boot_seq_assertions #(.OTP_CYCLES(OTP_C), .LOCK_CYCLES(LOCK_C),
    .BOOT_CYCLES(OTP_C), .LINE_CYCLES(LINE_C), .FRAME_LINES(LINES_C))
    u_chk (.clock_i(clock_i), .srst_i(srst_i),
    .chip_reset_n(i_boot_seq_if.chip_reset_n),
    .mode_wr(i_boot_seq_if.mode_wr), .mode_wdata(i_boot_seq_if.mode_wdata),
    .line_stop(i_boot_seq_if.line_stop),
    .boot_done(i_boot_seq_if.boot_done),
    .pll_locked(i_boot_seq_if.pll_locked),
    .streaming(i_boot_seq_if.streaming),
    .frame_end(i_boot_seq_if.frame_end), .line_end(i_boot_seq_if.line_end));
  initial forever #25 clock_i = ~clock_i;
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] sv, ev);
    cmp_count++;
    if (sv !== ev) begin
      n_mismatch++;
      $display("Error %s expected %0d seen %0d", nm, ev, sv);
    end
  endtask : chk
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict
  // a used-up wait counts as a mismatch and ends the run
  task automatic limit(input string nm, input int lim);
    if (n >= lim) begin
      chk(nm, 32'h0, 32'h1);
      give_verdict();
    end
  endtask : limit
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_power_up;
    sup_ok = 1'b1;
    for (n = 0; n < 99 && i_boot_seq_if.chip_reset_n !== 1'b1; n++)
      @(negedge clock_i);
    limit("release wait", 99);
    chk("settle", n >= SET_C, 1'b1);
    for (n = 0; n < 99 && i_boot_seq_if.boot_done !== 1'b1; n++) begin
      @(negedge clock_i);
      if (n == 8) chk("load active", {stby, load_o}, 2'h1);
    end
    limit("boot wait", 99);
    chk("boot min", n >= OTP_C, 1'b1);
    chk("boot max", n <= OTP_C + 8, 1'b1);
    for (n = 0; n < 50 && ready !== 1'b1; n++) @(negedge clock_i);
    limit("ready wait", 50);
    $display("done power up");
  endtask : t_power_up
  task automatic t_stream(input logic ls);
    lstop = ls;
    req = 1'b1;
    for (n = 0; n < 50 && i_boot_seq_if.mode_wr !== 1'b1; n++)
      @(negedge clock_i);
    limit("start write", 50);
    for (n = 0; n < 99 && i_boot_seq_if.streaming !== 1'b1; n++)
      @(negedge clock_i);
    limit("stream wait", 99);
    chk("lock time", n, LOCK_C + 1);
    repeat (2) @(negedge clock_i);
    chk("running", running, 1'b1);
    // stop mid-line so the drain has real work to do
    repeat (LINE_C * 3 + 3) @(negedge clock_i);
    req = 1'b0;
    seen = 1'b0;
    for (n = 0; n < 99 && i_boot_seq_if.streaming === 1'b1; n++) begin
      @(negedge clock_i);
      // the boundary pulse stands in the cycle streaming drops
      seen = ls ? i_boot_seq_if.line_end : i_boot_seq_if.frame_end;
    end
    limit("stop wait", 99);
    chk("boundary", seen, 1'b1);
    chk("drain len", n <= (ls ? LINE_C : LINE_C * LINES_C) + 4, 1);
    repeat (4) @(negedge clock_i);
    chk("standby", {pll_en, ready}, 2'h1);
    $display("done stream %0d", ls);
  endtask : t_stream
  task automatic t_power_down;
    sup_ok = 1'b0;
    repeat (2) @(negedge clock_i);
    chk("reset pin", i_boot_seq_if.chip_reset_n, 1'b0);
    repeat (8) @(negedge clock_i);
    chk("hard standby", stby, 1'b1);
    chk("boot cleared", i_boot_seq_if.boot_done, 1'b0);
    chk("safe off", safe_off, 1'b1);
    $display("done power down");
  endtask : t_power_down
  initial begin
    repeat (8) @(negedge clock_i);
    srst_i = 1'b0;
    chk("reset stby", stby, 1'b1);
    chk("reset pin low", i_boot_seq_if.chip_reset_n, 1'b0);
    t_power_up();
    t_stream(1'b0);
    t_stream(1'b1);
    t_power_down();
    // request held before boot ends must wait for the boot count
    req = 1'b1;
    t_power_up();
    t_stream(1'b0);
    t_power_down();
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
